// [odcr_pkg.sv]
// Shared constants and state types of the oscillator identity and device-control block.
// Assumes a single 25 MHz clock and an I2C host driving the serial pins from outside.
`default_nettype none

package odcr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_MASK_REV = 8'h03;
	localparam logic [7:0] REG_BUS_ADDR = 8'h08;
	localparam logic [7:0] REG_IMG_REV = 8'h09;
	localparam logic [7:0] REG_DEVICE_CONTROL = 8'h0A;
	localparam logic [7:0] REG_SOFT_RST = 8'h0B;

	// ----------------------------------------------------------------
	// Fixed values and reset values
	// ----------------------------------------------------------------
	// The mask revision value is arbitrary.
	localparam logic [7:0] MASK_REV_VALUE = 8'h5A;
	localparam logic [7:0] BUS_ADDR_RESET = 8'h58;
	localparam logic [7:0] IMG_REV_RESET = 8'h00;
	localparam logic PDN_RESET = 1'b0;
	localparam logic SEL_RESET = 1'b1;
	localparam logic [2:0] SPARE_RESET = 3'h0;
	localparam logic CAL_RESET = 1'b0;
	localparam logic AUTO_RESET = 1'b1;
	// Idle levels of SCL, SDA, reset pin, strap high, strap float.
	localparam logic [4:0] SYNC_RESET = 5'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_PDN_BIT = 6;
	localparam int CTL_SEL_BIT = 5;
	localparam int CTL_SPARE_MSB = 4;
	localparam int CTL_SPARE_LSB = 2;
	localparam int CTL_CAL_BIT = 1;
	localparam int CTL_AUTO_BIT = 0;
	localparam int ADDR_KEEP_MSB = 7;
	localparam int ADDR_KEEP_LSB = 3;
	localparam int SOFT_RST_BIT = 0;

	// ----------------------------------------------------------------
	// Strap codes for the two low address bits
	// ----------------------------------------------------------------
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_FLOAT = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h3;

	// ----------------------------------------------------------------
	// Nonvolatile memory image layout and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] NVM_ADR_BUS = 8'h00;
	localparam logic [7:0] NVM_ADR_REV = 8'h01;
	localparam logic [7:0] NVM_ADR_CTL = 8'h02;
	localparam logic [1:0] FETCH_BUS = 2'h0;
	localparam logic [1:0] FETCH_REV = 2'h1;
	localparam logic [1:0] FETCH_LAST = 2'h2;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_LAST = 4'h7;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_AACK, I_REG, I_RACK, I_WDATA, I_WACK, I_RDATA, I_MACK
	} odcr_i2c_t;

	typedef enum logic [2:0] {
		Q_FETCH, Q_HALT, Q_CAL, Q_LOCK, Q_RUN, Q_PDN
	} odcr_seq_t;

endpackage

`default_nettype wire

// [odcr_top.sv]
// Identity, bus address, image revision and device-control registers behind an I2C target.
// Assumes a nonvolatile memory read port, a PLL calibration engine and a lock detector
// on the same clock; serial pins, reset pin and strap sense arrive asynchronously.
//
// Overview of operation
// RULE1 - Fixed read-only mask revision byte.
// RULE2 - Target address read-only, loaded from memory.
// RULE3 - Strap pin sets address bits two to one.
// RULE4 - Image revision refetched after reset or commit.
// RULE5 - Hardware reset enables PLL and calibrates it. Code does so only when the fetched word has autostart set and power-down clear.
// RULE6 - Power-down write disables PLL, resets calibration.
// RULE7 - Clearing power-down re-enables PLL, recalibrates.
// RULE8 - Trigger bit rising edge starts calibration.
// RULE9 - Trigger bit clears itself when calibration completes.
// RULE10 - Autostart overrides trigger during reset sequencing.
// RULE11 - Autostart set: lock then enable output.
// RULE12 - Power-on, reset pin, software bit reset.
// RULE13 - Autostart clear: halt after configuration.
// RULE14 - Writing autostart one starts the lock.
// RULE15 - Host keeps output-type select at one.
// RULE16 - Writes to read-only registers are ignored.
`default_nettype none

module odcr_top
	import odcr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic resetPinN,
	input wire logic addrPinHigh,
	input wire logic addrPinFloat,
	output logic nvmRdReq,
	output logic [7:0] nvmRdAddr,
	input wire logic nvmRdAck,
	input wire logic [7:0] nvmRdData,
	input wire logic nvmCommit,
	input wire logic calDone,
	input wire logic pllLocked,
	output logic pllEnable,
	output logic calStart,
	output logic calReset,
	output logic outEnable
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [4:0] syncA_r;
	logic [4:0] syncB_r;
	logic sclPrev_r;
	logic sdaPrev_r;
	logic [1:0] warm_r;
	wire logic syncReady = warm_r[1];
	wire logic [4:0] asyncIn = {sclIn, sdaIn, resetPinN, addrPinHigh, addrPinFloat};
	wire logic sclS = syncB_r[4];
	wire logic sdaS = syncB_r[3];
	wire logic resetPinS = syncB_r[2];
	wire logic strapHighS = syncB_r[1];
	wire logic strapFloatS = syncB_r[0];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			syncA_r <= SYNC_RESET;
			syncB_r <= SYNC_RESET;
			sclPrev_r <= 1'b1;
			sdaPrev_r <= 1'b1;
			warm_r <= 2'h0;
		end else if (clkEn) begin
			syncA_r <= asyncIn;
			syncB_r <= syncA_r;
			sclPrev_r <= sclS;
			sdaPrev_r <= sdaS;
			warm_r <= {warm_r[0], 1'b1};
		end
	end

	wire logic sclRise = sclS && !sclPrev_r;
	wire logic sclFall = !sclS && sclPrev_r;
	wire logic startCond = sclS && sclPrev_r && sdaPrev_r && !sdaS;
	wire logic stopCond = sclS && sclPrev_r && !sdaPrev_r && sdaS;

	// ----------------------------------------------------------------
	// Register storage and read decode
	// ----------------------------------------------------------------
	logic [7:0] busAddr_r;
	logic [7:0] imgRev_r;
	logic pllPowerDown_r;
	logic outTypeSel_r;
	logic [2:0] ctlSpare_r;
	logic calibrationTrigger_r;
	logic autoLockOnReset_r;
	logic [7:0] ptr_r;

	wire logic [7:0] devCtlView = {1'b0, pllPowerDown_r, outTypeSel_r, ctlSpare_r,
		calibrationTrigger_r, autoLockOnReset_r};

	// Unmapped offsets and the soft reset register read as zero.
	function automatic logic [7:0] readReg(input logic [7:0] addr);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			REG_MASK_REV: val = MASK_REV_VALUE; // see RULE1
			REG_BUS_ADDR: val = busAddr_r; // see RULE2
			REG_IMG_REV: val = imgRev_r;
			REG_DEVICE_CONTROL: val = devCtlView;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	wire logic [7:0] ptrNext = ptr_r + 8'h01;
	wire logic [7:0] rdNow = readReg(ptr_r);
	wire logic [7:0] rdNext = readReg(ptrNext);

	// ----------------------------------------------------------------
	// I2C target
	// ----------------------------------------------------------------
	odcr_i2c_t i2c_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	logic [7:0] tx_r;
	logic rw_r;
	logic mAck_r;
	logic sdaOe_r;
	logic sdaOut_r;
	logic wrStb_r;
	logic [7:0] wrAddr_r;
	logic [7:0] wrData_r;

	wire logic byteIn = sclFall && (bitCnt_r == BYTE_BITS);
	wire logic addrHit = shift_r[7:1] == busAddr_r[7:1];

	// The bus is open drain: a one is sent by releasing SDA, so only the enable moves.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			i2c_r <= I_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			mAck_r <= 1'b0;
			sdaOe_r <= 1'b0;
			sdaOut_r <= 1'b0;
			wrStb_r <= 1'b0;
			wrAddr_r <= 8'h00;
			wrData_r <= 8'h00;
			ptr_r <= 8'h00;
		end else if (clkEn) begin
			wrStb_r <= 1'b0;
			if (startCond) begin
				i2c_r <= I_ADDR;
				bitCnt_r <= 4'h0;
				sdaOe_r <= 1'b0;
			end else if (stopCond) begin
				i2c_r <= I_IDLE;
				sdaOe_r <= 1'b0;
			end else begin
				case (i2c_r)
					I_ADDR, I_REG, I_WDATA: begin
						if (sclRise) begin
							shift_r <= {shift_r[6:0], sdaS};
							bitCnt_r <= bitCnt_r + 4'h1;
						end else if (byteIn) begin
							bitCnt_r <= 4'h0;
							if (i2c_r == I_ADDR) begin
								if (addrHit) begin
									sdaOe_r <= 1'b1;
									rw_r <= shift_r[0];
									i2c_r <= I_AACK;
								end else begin
									i2c_r <= I_IDLE;
								end
							end else if (i2c_r == I_REG) begin
								ptr_r <= shift_r;
								sdaOe_r <= 1'b1;
								i2c_r <= I_RACK;
							end else begin
								wrStb_r <= 1'b1;
								wrAddr_r <= ptr_r;
								wrData_r <= shift_r;
								ptr_r <= ptrNext;
								sdaOe_r <= 1'b1;
								i2c_r <= I_WACK;
							end
						end
					end
					I_AACK: begin
						if (sclFall) begin
							if (rw_r) begin
								tx_r <= rdNow;
								sdaOe_r <= !rdNow[7];
								i2c_r <= I_RDATA;
							end else begin
								sdaOe_r <= 1'b0;
								i2c_r <= I_REG;
							end
						end
					end
					I_RACK, I_WACK: begin
						if (sclFall) begin
							sdaOe_r <= 1'b0;
							i2c_r <= I_WDATA;
						end
					end
					I_RDATA: begin
						if (sclFall) begin
							if (bitCnt_r == TX_LAST) begin
								bitCnt_r <= 4'h0;
								sdaOe_r <= 1'b0;
								i2c_r <= I_MACK;
							end else begin
								bitCnt_r <= bitCnt_r + 4'h1;
								tx_r <= {tx_r[6:0], 1'b0};
								sdaOe_r <= !tx_r[6];
							end
						end
					end
					I_MACK: begin
						if (sclRise) begin
							mAck_r <= !sdaS;
						end else if (sclFall) begin
							if (mAck_r) begin
								ptr_r <= ptrNext;
								tx_r <= rdNext;
								sdaOe_r <= !rdNext[7];
								i2c_r <= I_RDATA;
							end else begin
								i2c_r <= I_IDLE;
							end
						end
					end
					default: begin
						i2c_r <= I_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Write decode and sequencing events
	// ----------------------------------------------------------------
	odcr_seq_t seq_r;
	logic [1:0] fetchIdx_r;
	logic revFetch_r;
	logic nvmRdReq_r;
	logic [7:0] nvmRdAddr_r;
	logic pllEnable_r;
	logic calStart_r;
	logic calReset_r;
	logic outEnable_r;

	// Only the control and soft reset offsets have write decodes; others drop. (see RULE16)
	wire logic wrCtl = wrStb_r && (wrAddr_r == REG_DEVICE_CONTROL);
	wire logic wrSoft = wrStb_r && (wrAddr_r == REG_SOFT_RST);
	wire logic devReset = !resetPinS || (wrSoft && wrData_r[SOFT_RST_BIT]); // see RULE12
	// The trigger is honoured only once sequencing has finished. (see RULE10)
	wire logic calTrigWrite = wrCtl && wrData_r[CTL_CAL_BIT] && !calibrationTrigger_r
		&& (seq_r == Q_RUN); // see RULE8
	wire logic pdnSet = wrCtl && wrData_r[CTL_PDN_BIT] && (seq_r != Q_FETCH); // see RULE6
	wire logic pdnClear = wrCtl && !wrData_r[CTL_PDN_BIT] && (seq_r == Q_PDN); // see RULE7
	wire logic autoKick = wrCtl && wrData_r[CTL_AUTO_BIT] && !wrData_r[CTL_PDN_BIT]
		&& (seq_r == Q_HALT); // see RULE14
	wire logic nvmGot = nvmRdReq_r && nvmRdAck;
	wire logic fetching = seq_r == Q_FETCH;
	wire logic fetchDone = fetching && nvmGot && (fetchIdx_r == FETCH_LAST);
	wire logic [1:0] strapCode = strapHighS ? STRAP_HIGH :
		(strapFloatS ? STRAP_FLOAT : STRAP_LOW); // see RULE3
	wire logic [7:0] fetchAddr = (fetchIdx_r == FETCH_BUS) ? NVM_ADR_BUS :
		((fetchIdx_r == FETCH_REV) ? NVM_ADR_REV : NVM_ADR_CTL);
	wire logic nvmWant = fetching || revFetch_r;

	// ----------------------------------------------------------------
	// Memory fetch port
	// ----------------------------------------------------------------
	// Request drops for a cycle after each acknowledge so no answer is taken twice.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			nvmRdReq_r <= 1'b0;
			nvmRdAddr_r <= NVM_ADR_BUS;
		end else if (clkEn) begin
			// Fetches wait for real pin values, so the strap never comes from reset state.
			nvmRdReq_r <= syncReady && !devReset && nvmWant && !nvmGot; // see RULE3
			nvmRdAddr_r <= fetching ? fetchAddr : NVM_ADR_REV;
		end
	end

	// ----------------------------------------------------------------
	// Device sequencer and control register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seq_r <= Q_FETCH;
			fetchIdx_r <= FETCH_BUS;
			revFetch_r <= 1'b0;
			busAddr_r <= BUS_ADDR_RESET;
			imgRev_r <= IMG_REV_RESET;
			pllPowerDown_r <= PDN_RESET;
			outTypeSel_r <= SEL_RESET;
			ctlSpare_r <= SPARE_RESET;
			calibrationTrigger_r <= CAL_RESET;
			autoLockOnReset_r <= AUTO_RESET;
			pllEnable_r <= 1'b0;
			calStart_r <= 1'b0;
			calReset_r <= 1'b0;
			outEnable_r <= 1'b0;
		end else if (clkEn) begin
			calStart_r <= 1'b0;
			calReset_r <= 1'b0;
			if (devReset) begin
				seq_r <= Q_FETCH; // see RULE12
				fetchIdx_r <= FETCH_BUS;
				revFetch_r <= 1'b0;
				pllPowerDown_r <= PDN_RESET;
				outTypeSel_r <= SEL_RESET;
				ctlSpare_r <= SPARE_RESET;
				calibrationTrigger_r <= CAL_RESET;
				autoLockOnReset_r <= AUTO_RESET;
				pllEnable_r <= 1'b0;
				outEnable_r <= 1'b0;
				calReset_r <= 1'b1;
			end else begin
				if (nvmGot && fetching) begin
					fetchIdx_r <= fetchIdx_r + 2'h1;
					case (fetchIdx_r)
						FETCH_BUS: busAddr_r <= {nvmRdData[ADDR_KEEP_MSB:ADDR_KEEP_LSB],
							strapCode, 1'b0}; // see RULE2
						FETCH_REV: imgRev_r <= nvmRdData; // see RULE4
						default: begin
							pllPowerDown_r <= nvmRdData[CTL_PDN_BIT];
							outTypeSel_r <= nvmRdData[CTL_SEL_BIT];
							ctlSpare_r <= nvmRdData[CTL_SPARE_MSB:CTL_SPARE_LSB];
							autoLockOnReset_r <= nvmRdData[CTL_AUTO_BIT];
						end
					endcase
				end else if (nvmGot) begin
					imgRev_r <= nvmRdData; // see RULE4
				end
				// A commit landing on the acknowledge cycle still schedules a refetch.
				if (nvmCommit && !fetching) begin
					revFetch_r <= 1'b1; // see RULE4
				end else if (nvmGot && !fetching) begin
					revFetch_r <= 1'b0;
				end
				if (wrCtl && !fetching) begin
					pllPowerDown_r <= wrData_r[CTL_PDN_BIT];
					outTypeSel_r <= wrData_r[CTL_SEL_BIT];
					ctlSpare_r <= wrData_r[CTL_SPARE_MSB:CTL_SPARE_LSB];
					autoLockOnReset_r <= wrData_r[CTL_AUTO_BIT];
				end
				case (seq_r)
					Q_FETCH: begin
						if (fetchDone) begin
							if (nvmRdData[CTL_PDN_BIT]) begin
								seq_r <= Q_PDN;
							end else if (nvmRdData[CTL_AUTO_BIT]) begin
								seq_r <= Q_CAL; // see RULE5
								pllEnable_r <= 1'b1; // see RULE11
								calStart_r <= 1'b1;
							end else begin
								seq_r <= Q_HALT; // see RULE13
							end
						end
					end
					Q_HALT: begin
						if (autoKick) begin
							seq_r <= Q_CAL; // see RULE14
							pllEnable_r <= 1'b1;
							calStart_r <= 1'b1;
						end
					end
					Q_CAL: begin
						if (calDone) begin
							seq_r <= Q_LOCK;
						end
					end
					Q_LOCK: begin
						if (pllLocked) begin
							seq_r <= Q_RUN;
							outEnable_r <= 1'b1; // see RULE11
						end
					end
					Q_RUN: begin
						if (calTrigWrite) begin
							calStart_r <= 1'b1; // see RULE8
						end
					end
					Q_PDN: begin
						if (pdnClear) begin
							seq_r <= Q_CAL; // see RULE7
							pllEnable_r <= 1'b1;
							calStart_r <= 1'b1;
						end
					end
					default: begin
						seq_r <= Q_FETCH;
					end
				endcase
				// The trigger set wins over completion in the same cycle.
				if (pdnSet) begin
					calibrationTrigger_r <= 1'b0;
				end else if (calTrigWrite) begin
					calibrationTrigger_r <= 1'b1; // see RULE8
				end else if (calDone) begin
					calibrationTrigger_r <= 1'b0; // see RULE9
				end
				if (pdnSet) begin
					seq_r <= Q_PDN; // see RULE6
					pllEnable_r <= 1'b0;
					outEnable_r <= 1'b0;
					calStart_r <= 1'b0;
					calReset_r <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign sdaOut = sdaOut_r;
	assign sdaOe = sdaOe_r;
	assign nvmRdReq = nvmRdReq_r;
	assign nvmRdAddr = nvmRdAddr_r;
	assign pllEnable = pllEnable_r;
	assign calStart = calStart_r;
	assign calReset = calReset_r;
	assign outEnable = outEnable_r;

endmodule

`default_nettype wire

// [odcr_i2c_host.sv]
// I2C host model that drives the serial pins of the control block.
// Assumes the bench resolves SDA as an open-drain wire with a pull-up.
`default_nettype none
module odcr_i2c_host (
	input wire logic clock,
	output logic scl,
	output logic sdaLow,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Bus cycles
	// ----
	// Six-clock phases stay well above the two-clock minimum of the target.
	initial begin
		scl = 1'h1;
		sdaLow = 1'h0;
	end
	task automatic half();
		repeat (6) @(negedge clock);
	endtask
	// SDA only moves while SCL is low, so no bit is mistaken for a start or stop.
	task automatic bitX(input logic b, output logic rb);
		half();
		sdaLow = !b;
		half();
		scl = 1'h1;
		half();
		rb = sda;
		scl = 1'h0;
	endtask
	task automatic byteX(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
		output logic ackOut);
		for (int i = 7; i >= 0; i--) begin
			bitX(tx[i], rx[i]);
		end
		bitX(ackIn, ackOut);
	endtask
	task automatic start();
		half();
		sdaLow = 1'h0;
		half();
		scl = 1'h1;
		half();
		sdaLow = 1'h1;
		half();
		scl = 1'h0;
	endtask
	task automatic stop();
		half();
		sdaLow = 1'h1;
		half();
		scl = 1'h1;
		half();
		sdaLow = 1'h0;
		half();
	endtask
	// Result bit 8 is high when every byte sent by the host was acknowledged.
	task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
		input logic isRd, output logic [8:0] r);
		logic [7:0] rx;
		logic [3:0] a;
		start();
		byteX({dev, 1'h0}, 1'h1, rx, a[0]);
		byteX(ptr, 1'h1, rx, a[1]);
		if (isRd) begin
			start();
			byteX({dev, 1'h1}, 1'h1, rx, a[2]);
			byteX(8'hFF, 1'h1, rx, a[3]);
		end else begin
			byteX(d, 1'h1, rx, a[2]);
		end
		a[3] = 1'h0;
		stop();
		r = {a == 4'h0, rx};
	endtask
endmodule
`default_nettype wire

// [odcr_props.sv]
// Concurrent checks on the ports of the oscillator control block.
// Assumes the clock enable stays high while the checks run.
`default_nettype none
module odcr_props
	import odcr_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic resetPinN,
	input wire logic nvmRdReq,
	input wire logic [7:0] nvmRdAddr,
	input wire logic nvmRdAck,
	input wire logic nvmCommit,
	input wire logic pllLocked,
	input wire logic pllEnable,
	input wire logic calStart,
	input wire logic calReset,
	input wire logic outEnable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// ----
	// Checks
	// ----
	AST_ENABLE_CALS: assert property ($rose(pllEnable) |-> calStart)
		else $error("PLL on without calibration start");
	AST_CAL_NEEDS_PLL: assert property (calStart |-> pllEnable)
		else $error("calibration started with PLL off");
	AST_PDN_DROPS: assert property ($fell(pllEnable) |-> !outEnable && calReset)
		else $error("PLL off without output drop and cal reset");
	AST_OUT_AFTER_LOCK: assert property ($rose(outEnable) |-> $past(pllLocked))
		else $error("output enabled before lock");
	AST_OUT_NEEDS_PLL: assert property (outEnable |-> pllEnable)
		else $error("output on with PLL off");
	AST_NVM_HOLD: assert property (nvmRdReq && !nvmRdAck |=> nvmRdReq && $stable(nvmRdAddr))
		else $error("memory request dropped early");
	AST_NVM_GAP: assert property (nvmRdReq && nvmRdAck |=> !nvmRdReq)
		else $error("memory request not released");
	AST_COMMIT_FETCH: assert property (nvmCommit && outEnable |->
		##[1:4] (nvmRdReq && nvmRdAddr == NVM_ADR_REV))
		else $error("no refetch after commit");
	AST_PIN_RESET: assert property (!resetPinN [*6] |-> !pllEnable && !outEnable)
		else $error("reset pin did not stop the PLL");
endmodule
bind odcr_top odcr_props props (.clock, .rst, .resetPinN, .nvmRdReq, .nvmRdAddr, .nvmRdAck,
	.nvmCommit, .pllLocked, .pllEnable, .calStart, .calReset, .outEnable);
`default_nettype wire

// [odcr_tb_top.sv]
// Self-checking bench for the oscillator identity and device-control block.
// Assumes the I2C host model; memory, calibration and lock models live here.
`default_nettype none
module odcr_tb_top;
	import odcr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Stimulus and models
	// ----
	logic clock = 1'h0;
	logic rst = 1'h1;
	logic clkEn = 1'h1;
	logic resetPinN = 1'h1;
	logic addrPinHigh = 1'h0;
	logic addrPinFloat = 1'h0;
	logic nvmRdAck = 1'h0;
	logic [7:0] nvmRdData = 8'h00;
	logic nvmCommit = 1'h0;
	logic calDone = 1'h0;
	logic pllLocked = 1'h0;
	logic calOk = 1'h0;
	logic [7:0] nvmBus = 8'h5F;
	logic [7:0] nvmRev = 8'hA7;
	logic [7:0] nvmCtl = 8'h21;
	logic [6:0] dev = 7'h2C;
	int calCnt = 0;
	int calLen = 5;
	int startCnt = 0;
	int resetCnt = 0;
	int errorCnt = 0;
	int samplesChecked = 0;
	logic sclIn, sdaIn, hostSdaLow, sdaOut, sdaOe, nvmRdReq;
	logic pllEnable, calStart, calReset, outEnable;
	logic [7:0] nvmRdAddr, memVal;
	assign sdaIn = !(hostSdaLow || (sdaOe && !sdaOut));
	assign memVal = (nvmRdAddr == NVM_ADR_BUS) ? nvmBus :
		(nvmRdAddr == NVM_ADR_REV) ? nvmRev : nvmCtl;
	always #20 clock = !clock;
	odcr_top uut (.clock, .rst, .clkEn, .sclIn, .sdaIn, .sdaOut, .sdaOe, .resetPinN,
		.addrPinHigh, .addrPinFloat, .nvmRdReq, .nvmRdAddr, .nvmRdAck, .nvmRdData, .nvmCommit,
		.calDone, .pllLocked, .pllEnable, .calStart, .calReset, .outEnable);
	odcr_i2c_host host (.clock, .scl(sclIn), .sdaLow(hostSdaLow), .sda(sdaIn));
	// Between answers the memory shows inverted data, so a read taken late cannot pass.
	always @(negedge clock) begin
		nvmRdAck <= nvmRdReq && !nvmRdAck;
		nvmRdData <= (nvmRdReq && !nvmRdAck) ? memVal : ~memVal;
		calDone <= (calCnt == 1);
		calCnt <= calStart ? calLen : ((calCnt > 0 && !calReset) ? calCnt - 1 : 0);
		calOk <= pllEnable && (calOk || calCnt == 1);
		pllLocked <= pllEnable && calOk;
		startCnt <= startCnt + int'(calStart);
		resetCnt <= resetCnt + int'(calReset);
	end
	// ----
	// Shared tasks
	// ----
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrChk(input logic [7:0] ptr, input logic [7:0] d);
		logic [8:0] r;
		host.xfer(dev, ptr, d, 1'h0, r);
		check("write ack", {8'h00, r[8]}, 9'h001);
	endtask
	task automatic rdChk(input string what, input logic [7:0] ptr, input logic [7:0] exp);
		logic [8:0] r;
		host.xfer(dev, ptr, 8'h00, 1'h1, r);
		check(what, r, {1'h1, exp});
	endtask
	task automatic waitOut();
		int n;
		n = 0;
		while (outEnable !== 1'h1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		check("outEnable", {8'h00, outEnable}, 9'h001);
		if (n == 400) begin
			giveVerdict();
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic testBoot();
		waitOut();
		check("boot cal", 9'(startCnt), 9'h001);
		rdChk("maskRev", REG_MASK_REV, MASK_REV_VALUE);
		rdChk("busAddr", REG_BUS_ADDR, 8'h58);
		rdChk("imgRev", REG_IMG_REV, 8'hA7);
		rdChk("devCtl", REG_DEVICE_CONTROL, 8'h21);
		$display("boot done");
	endtask
	task automatic testReadOnly();
		logic [7:0] ptrs [3];
		logic [7:0] vals [3];
		ptrs = '{REG_MASK_REV, REG_BUS_ADDR, REG_IMG_REV};
		vals = '{MASK_REV_VALUE, 8'h58, 8'hA7};
		for (int i = 0; i < 3; i++) begin
			wrChk(ptrs[i], ~vals[i]);
			rdChk("read-only", ptrs[i], vals[i]);
		end
		wrChk(8'h0C, 8'h55);
		rdChk("unmapped", 8'h0C, 8'h00);
		$display("read-only done");
	endtask
	task automatic testTrigger();
		int c0;
		c0 = startCnt;
		// A long calibration keeps the trigger visibly set while the host polls it.
		calLen = 2000;
		wrChk(REG_DEVICE_CONTROL, 8'h23);
		check("trig start", 9'(startCnt - c0), 9'h001);
		rdChk("trig busy", REG_DEVICE_CONTROL, 8'h23);
		repeat (2000) @(negedge clock);
		calLen = 5;
		rdChk("trig clear", REG_DEVICE_CONTROL, 8'h21);
		$display("trigger done");
	endtask
	task automatic testPowerDown();
		int c0;
		int r0;
		c0 = startCnt;
		r0 = resetCnt;
		wrChk(REG_DEVICE_CONTROL, 8'h61);
		check("pdn pll", {8'h00, pllEnable}, 9'h000);
		check("pdn out", {8'h00, outEnable}, 9'h000);
		check("pdn calrst", 9'(resetCnt - r0), 9'h001);
		wrChk(REG_DEVICE_CONTROL, 8'h21);
		check("pll back", {8'h00, pllEnable}, 9'h001);
		check("recal", 9'(startCnt - c0), 9'h001);
		waitOut();
		$display("power-down done");
	endtask
	task automatic testCommit();
		nvmRev = 8'h3C;
		@(negedge clock);
		nvmCommit = 1'h1;
		@(negedge clock);
		nvmCommit = 1'h0;
		rdChk("refetch", REG_IMG_REV, 8'h3C);
		$display("commit done");
	endtask
	task automatic testHalt();
		int c0;
		int r0;
		nvmCtl = 8'h20;
		r0 = resetCnt;
		resetPinN = 1'h0;
		repeat (8) @(negedge clock);
		resetPinN = 1'h1;
		c0 = startCnt;
		check("pin reset", {8'h00, resetCnt > r0}, 9'h001);
		rdChk("halted ctl", REG_DEVICE_CONTROL, 8'h20);
		check("halted pll", {8'h00, pllEnable}, 9'h000);
		wrChk(REG_DEVICE_CONTROL, 8'h22);
		check("no trig", 9'(startCnt - c0), 9'h000);
		wrChk(REG_DEVICE_CONTROL, 8'h21);
		check("lock start", 9'(startCnt - c0), 9'h001);
		waitOut();
		$display("halt done");
	endtask
	task automatic testStrap();
		logic [8:0] r;
		nvmCtl = 8'h21;
		addrPinFloat = 1'h1;
		wrChk(REG_SOFT_RST, 8'h01);
		host.xfer(dev, REG_BUS_ADDR, 8'h00, 1'h1, r);
		check("old addr", {8'h00, r[8]}, 9'h000);
		dev = 7'h2D;
		rdChk("strap float", REG_BUS_ADDR, 8'h5A);
		waitOut();
		addrPinHigh = 1'h1;
		resetPinN = 1'h0;
		repeat (4) @(negedge clock);
		resetPinN = 1'h1;
		dev = 7'h2F;
		rdChk("strap high", REG_BUS_ADDR, 8'h5E);
		$display("strap done");
	endtask
	task automatic testFreeze();
		logic [8:0] r;
		clkEn = 1'h0;
		host.xfer(dev, REG_DEVICE_CONTROL, 8'h61, 1'h0, r);
		check("frozen ack", {8'h00, r[8]}, 9'h000);
		check("frozen pll", {8'h00, pllEnable}, 9'h001);
		clkEn = 1'h1;
		rdChk("frozen ctl", REG_DEVICE_CONTROL, 8'h21);
		nvmCtl = 8'h61;
		wrChk(REG_SOFT_RST, 8'h01);
		rdChk("boot pdn", REG_DEVICE_CONTROL, 8'h61);
		check("boot pdn pll", {8'h00, pllEnable}, 9'h000);
		$display("freeze done");
	endtask
	initial begin
		repeat (4) @(negedge clock);
		rst = 1'h0;
		testBoot();
		testReadOnly();
		testTrigger();
		testPowerDown();
		testCommit();
		testHalt();
		testStrap();
		testFreeze();
		giveVerdict();
	end
	initial begin
		repeat (100000) @(negedge clock);
		errorCnt++;
		giveVerdict();
	end
endmodule
`default_nettype wire
